// >>> rtl/sprot_defines.svh
// register map, field positions, reset values and timing counts
`ifndef SPROT_DEFINES_SVH
`define SPROT_DEFINES_SVH
`define SPROT_ADDR_W          8
`define SPROT_OFF_CTRL        8'h00
`define SPROT_OFF_MAP         8'h04
`define SPROT_OFF_SOFT_POS    8'h08
`define SPROT_OFF_SOFT_NEG    8'h0C
`define SPROT_OFF_PRESET      8'h10
`define SPROT_OFF_STATUS      8'h14
`define SPROT_CTRL_SERVO_EN   0
`define SPROT_CTRL_MODE_LO    1
`define SPROT_CTRL_SOFT_EN    3
`define SPROT_CTRL_ROT_SENSE  4
`define SPROT_CTRL_TEST_MODE  5
`define SPROT_CTRL_ALM_CLR    8
`define SPROT_CTRL_RST        32'h0000_0000
`define SPROT_MAP_RST         32'h0000_0000
`define SPROT_SOFT_POS_RST    32'h7FFF_FFFF
`define SPROT_SOFT_NEG_RST    32'h8000_0000
`define SPROT_PRESET_RST      32'h0000_0000
`define SPROT_FN_POS_LIM      0
`define SPROT_FN_NEG_LIM      1
`define SPROT_FN_EMG          2
`define SPROT_FN_ALM_RST      3
`define SPROT_FN_RAMP         4
`define SPROT_FN_PRESET       5
`define SPROT_RESP_OKAY       2'h0
`define SPROT_RESP_SLVERR     2'h2
`define SPROT_CLK_HZ          40000000
`define SPROT_KEY_HOLD_MS     1000
`define SPROT_KEY_HOLD_CYC    ((`SPROT_CLK_HZ / 1000) * `SPROT_KEY_HOLD_MS)
`endif

// >>> rtl/sprot_pkg.sv
// types shared by the servo protection input block
package sprot_pkg;
  typedef enum logic [1:0] {
    SPROT_MODE_POS    = 2'h0,
    SPROT_MODE_SPEED  = 2'h1,
    SPROT_MODE_TORQUE = 2'h2
  } sprot_mode_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } sprot_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sprot_axi_rsp_t;

  typedef struct packed {
    logic        moving;
    logic        dir_fwd;
    logic        home_active;
    logic        home_dir_pos;
    logic        home_shift;
    logic        home_finish;
    logic [31:0] fb_pos;
    logic [31:0] deviation;
  } sprot_motion_t;

  typedef struct packed {
    logic        ready;
    logic        pos_limit_det;
    logic        neg_limit_det;
    logic        limit_det;
    logic        stop_det;
    logic        stop_req;
    logic        third_torque_cap;
    logic        zero_speed_flag;
    logic        torque_zero;
    logic        inhibit_pos;
    logic        inhibit_neg;
    logic        ramp_select;
    logic        alarm_clear;
    logic        abs_alarm_clear;
    logic        preset_load;
    logic        preset_ack;
    logic        home_complete;
    logic        homing_abort;
    logic [31:0] cmd_pos_load;
    logic [31:0] fb_pos_load;
  } sprot_ctl_t;
endpackage : sprot_pkg

// >>> rtl/sprot_top.sv
// servo travel limits, forced stop, alarm clear, ramp select and position preset
`timescale 1ns/1ps
`include "sprot_defines.svh"

// Function
// - hardware limits act except in torque control
// - limit drop gives stop with third cap
// - under limit allow motion only away
// - codes 8/9 map limits, unmapped means clear
// - positive limit checked in both travel directions
// - positive trip moving negative locks both
// - outputs positive, negative and combined limit
// - soft window violation forces stop, flags limit
// - homing limit faults stop without completion
// - forced stop holds, highest priority, all modes
// - forced stop gives stop with third cap
// - code 10 maps stop, unmapped means run
// - ready needs servo enable and stop input
// - stop-detected output while stop input low
// - position/speed stop holds zero speed, tracks
// - torque stop zeroes torque, no alarm reset
// - alarm-clear input rising edge clears alarms
// - keypad hold, config tool, power-up clear
// - ramp select picks set one or two
// - preset edge loads command and feedback position
// - preset marks homed, clears absolute alarms
module sprot_top #(
  parameter int        NTERM        = 8,
  parameter int        TERM_IDX_W   = 3,
  parameter int        KEY_HOLD_CYC = `SPROT_KEY_HOLD_CYC
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus
  input  wire sprot_pkg::sprot_axi_req_t axi_req,
  output sprot_pkg::sprot_axi_rsp_t    axi_rsp,
  // sequence input terminals and keypad
  input  wire logic [NTERM-1:0]        term_in,
  input  wire logic                    keypad_set_in,
  // motion core
  input  wire sprot_pkg::sprot_motion_t motion,
  output sprot_pkg::sprot_ctl_t        ctl
);
  localparam int KCW = $clog2(KEY_HOLD_CYC + 1);

  // pick a mapped terminal, or the level an unmapped function reads as
  function automatic logic map_pick(input logic [31:0] map, input int fn,
                                    input logic [NTERM-1:0] t, input logic dflt);
    logic [3:0] f;
    f = map[fn*4 +: 4];
    map_pick = f[3] ? t[f[TERM_IDX_W-1:0]] : dflt;
  endfunction : map_pick

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = s[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    strb_merge = old;
  endfunction : strb_merge

  // input synchronisers
  logic [NTERM-1:0] term_s1_q, term_s2_q, term_s3_q;
  logic             key_s1_q, key_s2_q;
  always_ff @(posedge aclk) begin
    term_s1_q <= term_in;
    term_s2_q <= term_s1_q;
    term_s3_q <= term_s2_q;
    key_s1_q  <= keypad_set_in;
    key_s2_q  <= key_s1_q;
  end

  // registers
  logic [31:0] ctrl_q, map_q, soft_pos_q, soft_neg_q, preset_q;
  logic        cfg_clr_q;
  wire sprot_pkg::sprot_mode_t mode =
    sprot_pkg::sprot_mode_t'(ctrl_q[`SPROT_CTRL_MODE_LO +: 2]);
  wire torque_mode = (mode == sprot_pkg::SPROT_MODE_TORQUE);
  wire servo_en    = ctrl_q[`SPROT_CTRL_SERVO_EN];
  wire soft_en     = ctrl_q[`SPROT_CTRL_SOFT_EN];
  wire rot_sense   = ctrl_q[`SPROT_CTRL_ROT_SENSE];
  wire test_mode   = ctrl_q[`SPROT_CTRL_TEST_MODE];

  // mapped functions, current and previous sample
  wire pos_ok   = map_pick(map_q, `SPROT_FN_POS_LIM, term_s2_q, 1'b1);
  wire neg_ok   = map_pick(map_q, `SPROT_FN_NEG_LIM, term_s2_q, 1'b1);
  wire emg_ok   = map_pick(map_q, `SPROT_FN_EMG, term_s2_q, 1'b1);
  wire rst_now  = map_pick(map_q, `SPROT_FN_ALM_RST, term_s2_q, 1'b0);
  wire rst_prv  = map_pick(map_q, `SPROT_FN_ALM_RST, term_s3_q, 1'b0);
  wire ramp_now = map_pick(map_q, `SPROT_FN_RAMP, term_s2_q, 1'b0);
  wire pre_now  = map_pick(map_q, `SPROT_FN_PRESET, term_s2_q, 1'b0);
  wire pre_prv  = map_pick(map_q, `SPROT_FN_PRESET, term_s3_q, 1'b0);
  wire rst_rise = rst_now & ~rst_prv;
  wire pre_rise = pre_now & ~pre_prv;

  // travel limits
  wire pos_trip   = ~torque_mode & ~pos_ok;
  wire neg_trip   = ~torque_mode & ~neg_ok;
  wire moving_pos = motion.moving & (motion.dir_fwd ^ rot_sense);
  wire moving_neg = motion.moving & ~(motion.dir_fwd ^ rot_sense);
  wire soft_pos_v = soft_en & ($signed(motion.fb_pos) > $signed(soft_pos_q));
  wire soft_neg_v = soft_en & ($signed(motion.fb_pos) < $signed(soft_neg_q));
  logic lock_both_q;
  // a positive trip seen on negative travel blocks both ways until released
  wire lock_both_d = pos_trip & (lock_both_q | moving_neg);
  wire inh_pos     = pos_trip | soft_pos_v | lock_both_d;
  wire inh_neg     = neg_trip | soft_neg_v | lock_both_d;
  wire lim_any     = pos_trip | neg_trip | soft_pos_v | soft_neg_v;
  wire emg_stop    = ~emg_ok;

  // homing supervision
  logic hit_pos_q, hit_neg_q, seen_ls_q;
  wire ls_now     = 1'b0 | seen_ls_q;
  wire hit_pos_d  = motion.home_active & (hit_pos_q | pos_trip);
  wire hit_neg_d  = motion.home_active & (hit_neg_q | neg_trip);
  wire home_opp   = (motion.home_dir_pos & neg_trip) | (~motion.home_dir_pos & pos_trip);
  wire home_fault = motion.home_active &
                    ((hit_pos_d & hit_neg_d & ~ls_now) | home_opp |
                     (motion.home_shift & (pos_trip | neg_trip)));

  // alarm clear sources
  logic [KCW-1:0] key_cnt_q;
  logic           por_done_q;
  wire key_hold   = test_mode & key_s2_q;
  wire key_fire   = key_hold & (key_cnt_q == KCW'(KEY_HOLD_CYC - 1));
  wire alm_clr_d  = rst_rise | key_fire | cfg_clr_q | ~por_done_q;

  // bus slave
  logic             have_aw_q, have_w_q;
  logic [7:0]       waddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  wire aw_hs   = axi_req.awvalid & axi_rsp.awready;
  wire w_hs    = axi_req.wvalid & axi_rsp.wready;
  wire b_hs    = axi_rsp.bvalid & axi_req.bready;
  wire ar_hs   = axi_req.arvalid & axi_rsp.arready;
  wire r_hs    = axi_rsp.rvalid & axi_req.rready;
  wire wr_fire = have_aw_q & have_w_q & ~axi_rsp.bvalid;
  wire wa_ctrl = wr_fire & (waddr_q == `SPROT_OFF_CTRL);
  wire wa_map  = wr_fire & (waddr_q == `SPROT_OFF_MAP);
  wire wa_sp   = wr_fire & (waddr_q == `SPROT_OFF_SOFT_POS);
  wire wa_sn   = wr_fire & (waddr_q == `SPROT_OFF_SOFT_NEG);
  wire wa_pre  = wr_fire & (waddr_q == `SPROT_OFF_PRESET);
  wire wa_ok   = wa_ctrl | wa_map | wa_sp | wa_sn | wa_pre;
  wire [31:0] ctrl_new = strb_merge(ctrl_q, wdata_q, wstrb_q);
  wire [31:0] status_w = {20'h0_0000, ctl.homing_abort, ctl.home_complete, ctl.preset_ack,
                          lock_both_q, ctl.ramp_select, emg_stop, soft_neg_v, soft_pos_v,
                          neg_trip, pos_trip, ctl.ready, ctl.stop_req};
  wire        rd_ok    = (axi_req.araddr == `SPROT_OFF_CTRL) ||
                         (axi_req.araddr == `SPROT_OFF_MAP) ||
                         (axi_req.araddr == `SPROT_OFF_SOFT_POS) ||
                         (axi_req.araddr == `SPROT_OFF_SOFT_NEG) ||
                         (axi_req.araddr == `SPROT_OFF_PRESET) ||
                         (axi_req.araddr == `SPROT_OFF_STATUS);
  logic [31:0] rd_mux;
  always_comb begin
    unique case (axi_req.araddr)
      `SPROT_OFF_CTRL:     rd_mux = ctrl_q;
      `SPROT_OFF_MAP:      rd_mux = map_q;
      `SPROT_OFF_SOFT_POS: rd_mux = soft_pos_q;
      `SPROT_OFF_SOFT_NEG: rd_mux = soft_neg_q;
      `SPROT_OFF_PRESET:   rd_mux = preset_q;
      `SPROT_OFF_STATUS:   rd_mux = status_w;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp    <= '0;
      axi_rsp.awready <= 1'b1;
      axi_rsp.wready  <= 1'b1;
      axi_rsp.arready <= 1'b1;
      have_aw_q  <= 1'b0;
      have_w_q   <= 1'b0;
      waddr_q    <= 8'h00;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
    end else begin
      if (aw_hs) begin
        have_aw_q       <= 1'b1;
        waddr_q         <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end
      if (w_hs) begin
        have_w_q       <= 1'b1;
        wdata_q        <= axi_req.wdata;
        wstrb_q        <= axi_req.wstrb;
        axi_rsp.wready <= 1'b0;
      end
      if (wr_fire) begin
        have_aw_q     <= 1'b0;
        have_w_q      <= 1'b0;
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= wa_ok ? `SPROT_RESP_OKAY : `SPROT_RESP_SLVERR;
      end
      if (b_hs) begin
        axi_rsp.bvalid  <= 1'b0;
        axi_rsp.awready <= 1'b1;
        axi_rsp.wready  <= 1'b1;
      end
      if (ar_hs) begin
        axi_rsp.arready <= 1'b0;
        axi_rsp.rvalid  <= 1'b1;
        axi_rsp.rdata   <= rd_mux;
        axi_rsp.rresp   <= rd_ok ? `SPROT_RESP_OKAY : `SPROT_RESP_SLVERR;
      end
      if (r_hs) begin
        axi_rsp.rvalid  <= 1'b0;
        axi_rsp.arready <= 1'b1;
      end
    end
  end

  // register file; the alarm-clear bit is a strobe and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `SPROT_CTRL_RST;
      map_q      <= `SPROT_MAP_RST;
      soft_pos_q <= `SPROT_SOFT_POS_RST;
      soft_neg_q <= `SPROT_SOFT_NEG_RST;
      preset_q   <= `SPROT_PRESET_RST;
      cfg_clr_q  <= 1'b0;
    end else begin
      if (wa_ctrl) ctrl_q <= {ctrl_new[31:9], 1'b0, ctrl_new[7:0]};
      if (wa_map) map_q <= strb_merge(map_q, wdata_q, wstrb_q);
      if (wa_sp) soft_pos_q <= strb_merge(soft_pos_q, wdata_q, wstrb_q);
      if (wa_sn) soft_neg_q <= strb_merge(soft_neg_q, wdata_q, wstrb_q);
      if (wa_pre) preset_q <= strb_merge(preset_q, wdata_q, wstrb_q);
      cfg_clr_q <= wa_ctrl & ctrl_new[`SPROT_CTRL_ALM_CLR];
    end
  end

  // protection state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_both_q <= 1'b0;
      hit_pos_q   <= 1'b0;
      hit_neg_q   <= 1'b0;
      seen_ls_q   <= 1'b0;
      key_cnt_q   <= '0;
      por_done_q  <= 1'b0;
    end else begin
      lock_both_q <= lock_both_d;
      hit_pos_q   <= hit_pos_d;
      hit_neg_q   <= hit_neg_d;
      seen_ls_q   <= motion.home_active & (seen_ls_q | motion.home_finish);
      // count saturates so one long press clears only once
      if (!key_hold) key_cnt_q <= '0;
      else if (key_cnt_q != KCW'(KEY_HOLD_CYC)) key_cnt_q <= key_cnt_q + KCW'(1);
      por_done_q  <= 1'b1;
    end
  end

  // control outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= '0;
    end else begin
      ctl.ready            <= servo_en & emg_ok;
      ctl.pos_limit_det    <= pos_trip;
      ctl.neg_limit_det    <= neg_trip;
      ctl.limit_det        <= lim_any;
      ctl.stop_det         <= emg_stop;
      ctl.stop_req         <= emg_stop | lim_any | home_fault;
      ctl.third_torque_cap <= emg_stop | pos_trip | neg_trip;
      ctl.zero_speed_flag  <= emg_stop & ~torque_mode;
      ctl.torque_zero      <= emg_stop & torque_mode;
      ctl.inhibit_pos      <= emg_stop | inh_pos;
      ctl.inhibit_neg      <= emg_stop | inh_neg;
      ctl.ramp_select      <= ramp_now;
      ctl.alarm_clear      <= alm_clr_d;
      ctl.abs_alarm_clear  <= pre_rise;
      ctl.preset_load      <= pre_rise;
      if (pre_rise) begin
        ctl.cmd_pos_load <= preset_q;
        ctl.fb_pos_load  <= preset_q - motion.deviation;
      end
      // ack follows the preset input down; a new edge wins
      ctl.preset_ack    <= pre_rise | (ctl.preset_ack & pre_now);
      ctl.homing_abort  <= home_fault;
      if (pre_rise | (motion.home_finish & ~home_fault)) ctl.home_complete <= 1'b1;
      else if (home_fault | (motion.home_active & ~ctl.home_complete))
        ctl.home_complete <= ctl.home_complete & ~home_fault;
    end
  end

  // checks
  ready_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ctl.ready == $past(servo_en & emg_ok))
    else $error("ready does not follow enable and stop input");
  stop_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    emg_stop |=> ctl.stop_det && ctl.stop_req)
    else $error("stop input low without stop detect");
  limit_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    torque_mode && !soft_en && $stable(mode) |=> !ctl.pos_limit_det && !ctl.neg_limit_det)
    else $error("limit acted in torque control");
  zero_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    emg_stop && !torque_mode |=> ctl.zero_speed_flag && !ctl.torque_zero)
    else $error("forced stop without zero speed");
  torque_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    emg_stop && torque_mode |=> ctl.torque_zero && !ctl.zero_speed_flag)
    else $error("forced stop in torque control without zero torque");
  lock_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_trip && moving_neg |=> ctl.inhibit_pos && ctl.inhibit_neg)
    else $error("positive trip on negative travel did not lock");
  soft_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_pos_v || soft_neg_v |=> ctl.limit_det && ctl.stop_req)
    else $error("soft window left without stop");
  preset_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_rise |=> ctl.preset_load && ctl.cmd_pos_load == $past(preset_q) ##1 !ctl.preset_load)
    else $error("preset load not a single pulse with value");
  preset_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.preset_ack && !pre_now && !pre_rise |=> !ctl.preset_ack)
    else $error("preset ack did not drop with input");
  alarm_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_rise |=> ctl.alarm_clear)
    else $error("alarm clear edge lost");
  bresp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before taken");
  pos_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ctl.pos_limit_det == $past(pos_trip))
    else $error("positive limit output does not follow trip");
  neg_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ctl.neg_limit_det == $past(neg_trip))
    else $error("negative limit output does not follow trip");
  limit_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_trip || neg_trip |=> ctl.third_torque_cap)
    else $error("limit trip without third torque cap");
  stop_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    emg_stop |=> ctl.third_torque_cap)
    else $error("forced stop without third torque cap");
  inhibit_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_trip |=> ctl.inhibit_pos)
    else $error("positive motion allowed past tripped limit");
  inhibit_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    neg_trip |=> ctl.inhibit_neg)
    else $error("negative motion allowed past tripped limit");
  stop_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    emg_stop |=> ctl.inhibit_pos && ctl.inhibit_neg)
    else $error("motion allowed during forced stop");
  ramp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ctl.ramp_select == $past(ramp_now))
    else $error("ramp select does not follow input");
  preset_home_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_rise |=> ctl.home_complete && ctl.preset_ack && ctl.abs_alarm_clear)
    else $error("preset did not mark homed");
  homing_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
    home_fault && !pre_rise |=> ctl.homing_abort && ctl.stop_req && !ctl.home_complete)
    else $error("homing fault without abort");
  key_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    key_fire |=> ctl.alarm_clear)
    else $error("key hold did not clear alarms");
  // bus answers stand until taken, new requests wait for them
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before taken");
  rd_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while answer pending");
  wr_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while answer pending");
  emg_cov: cover property (@(posedge aclk) disable iff (!aresetn) emg_stop ##1 !emg_stop);
  lim_cov: cover property (@(posedge aclk) disable iff (!aresetn) pos_trip && moving_neg);
  pre_cov: cover property (@(posedge aclk) disable iff (!aresetn) pre_rise ##[1:20] !pre_now);
  home_cov: cover property (@(posedge aclk) disable iff (!aresetn) home_fault);
  key_cov: cover property (@(posedge aclk) disable iff (!aresetn) key_fire);
endmodule : sprot_top

// >>> tb/sprot_field_model.sv
// field side model: limit switches, stop button and host discrete outputs
`timescale 1ns/1ps
module sprot_field_model (
  // clock
  input  wire logic       aclk,
  // switch states chosen by the scenario
  input  wire logic [5:0] sw_on,
  // sequence terminals
  output logic      [7:0] term_q = 8'h00
);
  logic [1:0] spare_q = 2'h1;
  // spare pins toggle so an unmapped terminal never looks stable
  always @(posedge aclk) begin
    spare_q <= ~spare_q;
    // limits and stop are normally closed: high means healthy
    term_q  <= {spare_q, sw_on};
  end
endmodule : sprot_field_model

// >>> tb/testbench.sv
// self-checking bench for the servo protection input block
`timescale 1ns/1ps
`include "sprot_defines.svh"
module testbench;
  logic                      aclk = 1'b0;
  logic                      aresetn = 1'b0;
  logic                      keypad_set_in = 1'b0;
  logic [5:0]                sw_on = 6'h07;
  logic [7:0]                term_in;
  sprot_pkg::sprot_axi_req_t axi_req = '0;
  sprot_pkg::sprot_axi_rsp_t axi_rsp;
  sprot_pkg::sprot_motion_t  motion = '0;
  sprot_pkg::sprot_motion_t  mv = '0;
  sprot_pkg::sprot_ctl_t     ctl;
  int                        error_cnt = 0;
  int                        cmp_count = 0;
  int                        alm_n = 0;
  int                        pre_n = 0;
  int                        abs_n = 0;
  logic [31:0]               rd;
  logic [1:0]                rs;
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // short key hold keeps the keypad scenario brief
  sprot_top #(.KEY_HOLD_CYC(16)) i_sprot_top (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .term_in(term_in), .keypad_set_in(keypad_set_in), .motion(motion), .ctl(ctl));
  sprot_field_model i_sprot_field_model (.aclk(aclk), .sw_on(sw_on), .term_q(term_in));
  // pulses are counted, so a stuck or repeated pulse shows in the totals
  always @(posedge aclk) begin
    if (ctl.alarm_clear === 1'b1) alm_n++;
    if (ctl.preset_load === 1'b1) pre_n++;
    if (ctl.abs_alarm_clear === 1'b1) abs_n++;
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : step
  task automatic hang();
    error_cnt++;
    $display("Error bus answer expected within 40 cycles seen none");
    finish_test();
  endtask : hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_req.awaddr  <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) begin
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) begin
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk("bresp", rs, `SPROT_RESP_OKAY);
    step(3);
  endtask : wr
  // switches and motion change together, then the 3-edge sync path settles
  task automatic put(input logic [5:0] s);
    @(posedge aclk);
    sw_on  <= s;
    motion <= mv;
    step(6);
  endtask : put
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    step(6);
    chk("power-up clear", alm_n, 1);
    axi_rd(`SPROT_OFF_SOFT_POS, rd, rs);
    chk("soft pos reset", rd, `SPROT_SOFT_POS_RST);
    axi_rd(`SPROT_OFF_SOFT_NEG, rd, rs);
    chk("soft neg reset", rd, `SPROT_SOFT_NEG_RST);
    axi_rd(8'h40, rd, rs);
    chk("unmapped rresp", rs, `SPROT_RESP_SLVERR);
    axi_wr(8'h40, 32'h0000_00FF, rs);
    chk("unmapped bresp", rs, `SPROT_RESP_SLVERR);
    wr(`SPROT_OFF_CTRL, 32'h0000_0001);
    put(6'h00);
    chk("ready unmapped", ctl.ready, 1'b1);
    chk("pos limit unmapped", ctl.pos_limit_det, 1'b0);
    chk("ramp unmapped", ctl.ramp_select, 1'b0);
    wr(`SPROT_OFF_MAP, 32'h00DC_BA98);
    mv.moving  = 1'b1;
    mv.dir_fwd = 1'b1;
    put(6'h07);
    chk("ready", ctl.ready, 1'b1);
    chk("stop det idle", ctl.stop_det, 1'b0);
    put(6'h03);
    chk("stop det", ctl.stop_det, 1'b1);
    chk("ready in stop", ctl.ready, 1'b0);
    chk("stop req", ctl.stop_req, 1'b1);
    chk("zero speed", ctl.zero_speed_flag, 1'b1);
    chk("stop cap", ctl.third_torque_cap, 1'b1);
    wr(`SPROT_OFF_CTRL, 32'h0000_0005);
    chk("torque zero", ctl.torque_zero, 1'b1);
    chk("no zero speed", ctl.zero_speed_flag, 1'b0);
    chk("stop req torque", ctl.stop_req, 1'b1);
    put(6'h06);
    chk("stop released", ctl.stop_det, 1'b0);
    chk("limit in torque", ctl.pos_limit_det, 1'b0);
    wr(`SPROT_OFF_CTRL, 32'h0000_0001);
    chk("pos limit", ctl.pos_limit_det, 1'b1);
    chk("limit any", ctl.limit_det, 1'b1);
    chk("inhibit toward", ctl.inhibit_pos, 1'b1);
    chk("allow away", ctl.inhibit_neg, 1'b0);
    chk("limit cap", ctl.third_torque_cap, 1'b1);
    put(6'h05);
    chk("neg limit", ctl.neg_limit_det, 1'b1);
    chk("pos limit clear", ctl.pos_limit_det, 1'b0);
    chk("inhibit neg", ctl.inhibit_neg, 1'b1);
    mv.dir_fwd = 1'b0;
    put(6'h07);
    put(6'h06);
    chk("lock pos", ctl.inhibit_pos, 1'b1);
    chk("lock neg", ctl.inhibit_neg, 1'b1);
    put(6'h07);
    // reversed sense: reverse rotation is the positive direction
    wr(`SPROT_OFF_CTRL, 32'h0000_0011);
    put(6'h06);
    chk("sense pos", ctl.inhibit_pos, 1'b1);
    chk("sense no lock", ctl.inhibit_neg, 1'b0);
    mv.home_active  = 1'b1;
    mv.home_dir_pos = 1'b1;
    mv.dir_fwd      = 1'b1;
    wr(`SPROT_OFF_CTRL, 32'h0000_0001);
    put(6'h05);
    chk("homing abort", ctl.homing_abort, 1'b1);
    chk("not homed", ctl.home_complete, 1'b0);
    chk("homing stop", ctl.stop_req, 1'b1);
    mv = '0;
    put(6'h07);
    wr(`SPROT_OFF_SOFT_POS, 32'h0000_0064);
    wr(`SPROT_OFF_SOFT_NEG, 32'hFFFF_FF9C);
    wr(`SPROT_OFF_CTRL, 32'h0000_0009);
    mv.fb_pos = 32'h0000_0065;
    put(6'h07);
    chk("soft over", ctl.limit_det, 1'b1);
    chk("soft stop", ctl.stop_req, 1'b1);
    // host backs off into the window
    mv.fb_pos = 32'h0000_0064;
    put(6'h07);
    chk("soft back", ctl.limit_det, 1'b0);
    mv.fb_pos = 32'hFFFF_FF9B;
    put(6'h07);
    chk("soft under", ctl.limit_det, 1'b1);
    mv.fb_pos = 32'h0000_0000;
    put(6'h17);
    chk("ramp set two", ctl.ramp_select, 1'b1);
    put(6'h0F);
    step(10);
    put(6'h07);
    chk("clear edge", alm_n, 2);
    wr(`SPROT_OFF_CTRL, 32'h0000_0101);
    chk("tool clear", alm_n, 3);
    wr(`SPROT_OFF_CTRL, 32'h0000_0021);
    @(posedge aclk);
    keypad_set_in <= 1'b1;
    repeat (30) @(posedge aclk);
    keypad_set_in <= 1'b0;
    step(6);
    chk("key clear", alm_n, 4);
    wr(`SPROT_OFF_PRESET, 32'h0000_1234);
    mv.deviation = 32'h0000_0005;
    put(6'h27);
    chk("preset pulses", pre_n, 1);
    chk("cmd load", ctl.cmd_pos_load, 32'h0000_1234);
    chk("fb load", ctl.fb_pos_load, 32'h0000_122F);
    chk("homed", ctl.home_complete, 1'b1);
    chk("abs clear", abs_n, 1);
    chk("ack high", ctl.preset_ack, 1'b1);
    put(6'h07);
    chk("ack low", ctl.preset_ack, 1'b0);
    axi_rd(`SPROT_OFF_STATUS, rd, rs);
    chk("status", rd, 32'h0000_0402);
    finish_test();
  end
endmodule : testbench
